// [src/pad_pull_regs.svh]
// register offsets, field positions, reset values and sizes of the pad pull control
`ifndef PAD_PULL_REGS_SVH
`define PAD_PULL_REGS_SVH

// bus address width and register byte offsets
`define PP_ADDR_W 8
`define PP_CFG_OFFSET 8'h00
`define PP_STAT_OFFSET 8'h04

// pad configuration register fields
`define PP_GPD_BIT 25
`define PP_SPD_BIT 24
`define PP_CFG_RESET 32'h0000_0000

// status register fields
`define PP_STAT_VSEL_LSB 0
`define PP_STAT_SPD_LSB 4
`define PP_STAT_RESET_BIT 8
`define PP_STAT_DRAIN_BIT 9

// pad group counts
`define PP_GROUPS 4
`define PP_SPECIALS 4

`endif

// [src/pad_pull_pkg.sv]
// types shared by the pad pull control and its bench
`default_nettype none
package pad_pull_pkg;

  // reset sequencing states, one-hot
  typedef enum logic [2:0]
  {
    ST_HOLD = 3'b001,
    ST_RUN = 3'b010,
    ST_DRAIN = 3'b100
  } state_t;

  // software pull-disable bits of the pad configuration register
  typedef struct packed
  {
    logic special;
    logic general;
  } pull_ctrl_t;

  // one apb request as the slave sees it
  typedef struct packed
  {
    logic sel;
    logic en;
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
  } apb_req_t;

endpackage
`default_nettype wire

// [src/pad_pull_reset_control.sv]
// pad pull-up and pull-down control through power-on, hard and soft reset
//
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`include "pad_pull_regs.svh"
`default_nettype none

module pad_pull_reset_control
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic hardResetInN,
  input wire logic busPending,
  input wire logic configValid,
  input wire logic [`PP_GROUPS-1:0] lowVoltFunc,
  input wire logic [`PP_SPECIALS-1:0] debugFunc,
  input wire logic [`PP_SPECIALS-1:0] driverEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PP_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [`PP_GROUPS-1:0] voltSelect,
  output logic generalPullDisable,
  output logic [`PP_SPECIALS-1:0] specialPullDisable,
  output logic [`PP_GROUPS-1:0] pullUpEn,
  output logic highVoltPullEn,
  output logic [`PP_SPECIALS-1:0] specialPullEn,
  output logic resetActive
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  pad_pull_pkg::state_t state_reg;
  pad_pull_pkg::state_t state_next;
  pad_pull_pkg::pull_ctrl_t ctrl_reg;
  pad_pull_pkg::pull_ctrl_t ctrl_next;
  pad_pull_pkg::apb_req_t apbReq;
  logic hrMeta_reg;
  logic hrSync_reg;
  logic hardReq;
  logic inHold;
  logic inRun;
  logic inDrain;
  logic toRun;
  logic hardClear;
  logic nextRun;
  logic nextHold;
  logic access;
  logic respond;
  logic cfgHit;
  logic statHit;
  logic writeFire;
  logic [31:0] cfgWord;
  logic [31:0] statWord;
  logic [31:0] readMux;
  logic [31:0] prdata_next;
  logic pready_next;
  logic pslverr_next;
  logic [`PP_GROUPS-1:0] vsel_next;
  logic [`PP_GROUPS-1:0] pullUp_next;
  logic [`PP_SPECIALS-1:0] spd_next;
  logic [`PP_SPECIALS-1:0] spEn_next;

  ////////////////////////////////////////////////////////////////////////////
  // hard reset pin synchroniser

  // two flops; only the second one feeds logic
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      hrMeta_reg <= 1'b1;
      hrSync_reg <= 1'b1;
    end
    else
    begin
      hrMeta_reg <= hardResetInN;
      hrSync_reg <= hrMeta_reg;
    end
  end

  // hard reset is acted on synchronously so a pending bus cycle is safe
  assign hardReq = ~hrSync_reg;

  ////////////////////////////////////////////////////////////////////////////
  // reset sequencing

  // state decode
  assign inHold = (state_reg == pad_pull_pkg::ST_HOLD);
  assign inRun = (state_reg == pad_pull_pkg::ST_RUN);
  assign inDrain = (state_reg == pad_pull_pkg::ST_DRAIN);

  // hold: pulls on; run: function applied; drain: wait for bus to finish.
  // no soft reset input exists: soft reset must not touch any of this
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      pad_pull_pkg::ST_HOLD:
      begin
        if (configValid && !hardReq)
        begin
          state_next = pad_pull_pkg::ST_RUN;
        end
      end
      pad_pull_pkg::ST_RUN:
      begin
        if (hardReq)
        begin
          state_next = pad_pull_pkg::ST_DRAIN;
        end
      end
      pad_pull_pkg::ST_DRAIN:
      begin
        if (!busPending)
        begin
          state_next = pad_pull_pkg::ST_HOLD;
        end
      end
      default:
      begin
        state_next = pad_pull_pkg::ST_HOLD;
      end
    endcase
  end

  // transition strobes
  assign nextRun = (state_next == pad_pull_pkg::ST_RUN);
  assign nextHold = (state_next == pad_pull_pkg::ST_HOLD);
  assign toRun = inHold & nextRun;
  assign hardClear = inDrain & nextHold;

  // power-on reset lands in hold with every pull on
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= pad_pull_pkg::ST_HOLD;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave, one wait state per transfer

  // bundle the bus request
  assign apbReq = '{sel: psel, en: penable, wr: pwrite,
    addr: paddr, wdata: pwdata};

  // address decode and phase detection
  assign access = apbReq.sel & apbReq.en;
  assign respond = access & ~pready;
  assign cfgHit = (apbReq.addr == `PP_CFG_OFFSET);
  assign statHit = (apbReq.addr == `PP_STAT_OFFSET);
  assign writeFire = access & pready & apbReq.wr & cfgHit;

  // readback words; reserved bits read zero
  always_comb
  begin
    cfgWord = `PP_CFG_RESET;
    cfgWord[`PP_GPD_BIT] = ctrl_reg.general;
    cfgWord[`PP_SPD_BIT] = ctrl_reg.special;
    statWord = 32'h0000_0000;
    statWord[`PP_STAT_VSEL_LSB +: `PP_GROUPS] = voltSelect;
    statWord[`PP_STAT_SPD_LSB +: `PP_SPECIALS] = specialPullDisable;
    statWord[`PP_STAT_RESET_BIT] = ~inRun;
    statWord[`PP_STAT_DRAIN_BIT] = inDrain;
  end

  // read select; unmapped reads return zero with an error
  assign readMux = cfgHit ? cfgWord : (statHit ? statWord : 32'h0000_0000);
  assign prdata_next = (respond && !apbReq.wr) ? readMux : 32'h0000_0000;
  assign pready_next = respond;
  assign pslverr_next = respond & ~(cfgHit | (statHit & ~apbReq.wr));

  // bus answer flops
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      prdata <= prdata_next;
      pready <= pready_next;
      pslverr <= pslverr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pad configuration register

  // hard reset clear beats a same-cycle write: the pads must come back on
  always_comb
  begin
    ctrl_next = ctrl_reg;
    if (hardClear)
    begin
      ctrl_next = '0;
    end
    else if (writeFire)
    begin
      ctrl_next.general = apbReq.wdata[`PP_GPD_BIT];
      ctrl_next.special = apbReq.wdata[`PP_SPD_BIT];
    end
  end

  // power-on clears the pull bits without a clock
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_reg <= '0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-group voltage select and pull-up enable

  genvar g;
  generate
    for (g = 0; g < `PP_GROUPS; g = g + 1)
    begin : groupGen
      // high through reset, then per function; a low select only rises
      // once drain is over, so the pull never fights a live bus cycle
      assign vsel_next[g] = toRun ? ~lowVoltFunc[g] :
        (nextHold ? 1'b1 : voltSelect[g]);
      // pad pull-up: select high and general disable clear
      assign pullUp_next[g] = vsel_next[g] & ~ctrl_next.general;
    end
  endgenerate

  // select and dual-voltage pull flops, all high at power-on
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      voltSelect <= {`PP_GROUPS{1'b1}};
      pullUpEn <= {`PP_GROUPS{1'b1}};
    end
    else
    begin
      voltSelect <= vsel_next;
      pullUpEn <= pullUp_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // general disable and high-voltage-only pads

  // one disable for all shared io and bridge pads
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      generalPullDisable <= 1'b0;
      highVoltPullEn <= 1'b1;
    end
    else
    begin
      generalPullDisable <= ctrl_next.general;
      highVoltPullEn <= ~ctrl_next.general;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // special disable for debug, tracking and arbitration pads

  genvar s;
  generate
    for (s = 0; s < `PP_SPECIALS; s = s + 1)
    begin : specialGen
      // forced low outside run; debug pads assert it at release
      assign spd_next[s] = nextRun & (ctrl_next.special | debugFunc[s]);
      // arbitration pads: pull off while the driver is on or the special disable is set
      assign spEn_next[s] = ~spd_next[s] & ~driverEn[s];
    end
  endgenerate

  // special pull flops; the same edge that enters run drops debug pulls
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      specialPullDisable <= {`PP_SPECIALS{1'b0}};
      specialPullEn <= {`PP_SPECIALS{1'b1}};
    end
    else
    begin
      specialPullDisable <= spd_next;
      specialPullEn <= spEn_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset indication

  // high whenever pads sit in their reset pull state
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      resetActive <= 1'b1;
    end
    else
    begin
      resetActive <= ~nextRun;
    end
  end

  // bus pads end reset with select low, so no pull fights fetches;
  // general io keeps select high, and its pull-up stays on until software sets the general disable

endmodule

`default_nettype wire

// [dv/board_bus_model.sv]
// board side model: external bus access timer and pulled pad levels
`timescale 1ns/10ps
`include "pad_pull_regs.svh"
`default_nettype none
module board_bus_model
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic busStart,
  input wire logic [`PP_GROUPS-1:0] pullUpEn,
  output logic busPending,
  output logic [`PP_GROUPS-1:0] padLevel
);
  logic [3:0] count_reg;
  logic [`PP_GROUPS-1:0] float_reg;

  // an access runs eight cycles; a stalled bus keeps the drain waiting
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      count_reg <= 4'h0;
    else if (busStart)
      count_reg <= 4'h8;
    else if (count_reg != 4'h0)
      count_reg <= count_reg - 4'h1;
  end

  // unpulled pads float, so show a changing pattern rather than a held level
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      float_reg <= '0;
    else
      float_reg <= ~float_reg;
  end

  assign busPending = count_reg != 4'h0;
  assign padLevel = pullUpEn | (float_reg & ~pullUpEn);
endmodule
`default_nettype wire

// [dv/pad_pull_properties.sv]
// concurrent checks on the pad pull control ports
`timescale 1ns/10ps
`include "pad_pull_regs.svh"
`default_nettype none
module pad_pull_properties
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic busPending,
  input wire logic configValid,
  input wire logic [`PP_GROUPS-1:0] lowVoltFunc,
  input wire logic [`PP_SPECIALS-1:0] debugFunc,
  input wire logic [`PP_SPECIALS-1:0] driverEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PP_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [`PP_GROUPS-1:0] voltSelect,
  input wire logic generalPullDisable,
  input wire logic [`PP_SPECIALS-1:0] specialPullDisable,
  input wire logic [`PP_GROUPS-1:0] pullUpEn,
  input wire logic highVoltPullEn,
  input wire logic [`PP_SPECIALS-1:0] specialPullEn,
  input wire logic resetActive
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  // pad enables follow their sources
  pull_eq_a:
  assert property (pullUpEn == (voltSelect & ~{`PP_GROUPS{generalPullDisable}}))
    else $error("pull-up enable differs from select and disable");
  high_volt_a:
  assert property (highVoltPullEn == !generalPullDisable)
    else $error("high-voltage pull enable wrong");
  driver_pull_a:
  assert property (specialPullEn == (~specialPullDisable & ~$past(driverEn)))
    else $error("special pull enable wrong");
  // reset exit takes the configured function
  release_select_a:
  assert property ($fell(resetActive) |-> voltSelect == ~$past(lowVoltFunc))
    else $error("select wrong at reset exit");
  hold_special_a:
  assert property ($fell(resetActive) |-> $past(specialPullDisable) == '0)
    else $error("special disable not low in reset");
  debug_disable_a:
  assert property (!resetActive |-> (specialPullDisable & $past(debugFunc)) == $past(debugFunc))
    else $error("debug pad pull not disabled");
  // select frozen while an external access drains, avoids bus contention
  drain_hold_a:
  assert property (resetActive && busPending && !configValid |=> $stable(voltSelect))
    else $error("select moved during drain");
  // one wait state, one-cycle answer, write lands on the ready edge
  ready_wait_a:
  assert property (psel && penable && !pready |=> pready)
    else $error("ready late");
  ready_pulse_a:
  assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  config_write_a:
  assert property (psel && penable && pready && pwrite && paddr == `PP_CFG_OFFSET && !resetActive
    |=> generalPullDisable == $past(pwdata[`PP_GPD_BIT]))
    else $error("general disable not written");

  cover property ($fell(resetActive));
  cover property (resetActive && busPending);
  cover property (pready && pslverr);
endmodule

bind pad_pull_reset_control pad_pull_properties i_pad_pull_properties
(
  .clock(clock), .rstn(rstn), .busPending(busPending), .configValid(configValid),
  .lowVoltFunc(lowVoltFunc), .debugFunc(debugFunc), .driverEn(driverEn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .voltSelect(voltSelect), .generalPullDisable(generalPullDisable),
  .specialPullDisable(specialPullDisable), .pullUpEn(pullUpEn),
  .highVoltPullEn(highVoltPullEn), .specialPullEn(specialPullEn), .resetActive(resetActive)
);
`default_nettype wire

// [dv/testbench.sv]
// self-checking bench of the pad pull control
`timescale 1ns/10ps
`include "pad_pull_regs.svh"
`default_nettype none
module testbench;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic hardResetInN = 1'b1;
  logic configValid = 1'b0;
  logic busStart = 1'b0;
  logic [3:0] lowVoltFunc = 4'h0;
  logic [3:0] debugFunc = 4'h0;
  logic [3:0] driverEn = 4'h0;
  pad_pull_pkg::apb_req_t req = '0;
  logic [31:0] prdata, q;
  logic pready, pslverr, generalPullDisable, highVoltPullEn, resetActive, busPending, e;
  logic [3:0] voltSelect, specialPullDisable, pullUpEn, specialPullEn;
  int num_errors = 0;
  int samples_checked = 0;

  always #20 clock = ~clock;

  pad_pull_reset_control i_pad_pull_reset_control (.clock(clock), .rstn(rstn),
    .hardResetInN(hardResetInN), .busPending(busPending), .configValid(configValid),
    .lowVoltFunc(lowVoltFunc), .debugFunc(debugFunc), .driverEn(driverEn), .psel(req.sel),
    .penable(req.en), .pwrite(req.wr), .paddr(req.addr), .pwdata(req.wdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .voltSelect(voltSelect),
    .generalPullDisable(generalPullDisable), .specialPullDisable(specialPullDisable),
    .pullUpEn(pullUpEn), .highVoltPullEn(highVoltPullEn), .specialPullEn(specialPullEn),
    .resetActive(resetActive));
  board_bus_model i_board_bus_model (.clock(clock), .rstn(rstn), .busStart(busStart),
    .pullUpEn(pullUpEn), .busPending(busPending), .padLevel());

  ////////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task complete_run;
    $display("checked %0d, errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // ends the run with an error if a bounded wait did not see its condition
  task give_up(input logic done);
    if (!done)
    begin
      num_errors++;
      complete_run;
    end
  endtask

  // request held until ready is sampled high at a rising edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    req <= '{sel: 1'b1, en: 1'b0, wr: wr, addr: a, wdata: d};
    @(posedge clock);
    req.en <= 1'b1;
    for (n = 0; n < 20 && pready !== 1'b1; n++)
      @(posedge clock);
    give_up(pready === 1'b1);
    q = prdata;
    e = pslverr;
    req <= '0;
    // one idle edge so the next setup never overwrites this release
    @(posedge clock);
  endtask

  task run_wait;
    for (int n = 0; n < 30 && resetActive !== 1'b0; n++)
      @(posedge clock);
    give_up(resetActive === 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task t_por;
    repeat (6) @(posedge clock);
    check("voltSelect", 32'hF, 32'(voltSelect));
    check("specialPullEn", 32'hF, 32'(specialPullEn));
    rstn <= 1'b1;
    repeat (4) @(posedge clock);
    apb(1'b0, `PP_STAT_OFFSET, 32'h0);
    check("status", 32'h0000_010F, q);
    $display("test por done");
  endtask

  task t_release;
    lowVoltFunc <= 4'h5;
    debugFunc <= 4'h3;
    configValid <= 1'b1;
    run_wait;
    check("voltSelect", 32'hA, 32'(voltSelect));
    check("pullUpEn", 32'hA, 32'(pullUpEn));
    check("specialPullDisable", 32'h3, 32'(specialPullDisable));
    lowVoltFunc <= 4'hF;
    driverEn <= 4'h8;
    repeat (2) @(posedge clock);
    check("specialPullEn", 32'h4, 32'(specialPullEn));
    check("voltSelect", 32'hA, 32'(voltSelect));
    $display("test release done");
  endtask

  task t_regs;
    apb(1'b1, `PP_STAT_OFFSET, 32'hFFFF_FFFF);
    check("pslverr", 32'h1, 32'(e));
    apb(1'b0, 8'h08, 32'h0);
    check("bad read error", 32'h1, 32'(e));
    check("bad read data", 32'h0, q);
    apb(1'b1, `PP_CFG_OFFSET, 32'h0100_0000);
    @(posedge clock);
    check("specialPullDisable", 32'hF, 32'(specialPullDisable));
    apb(1'b1, `PP_CFG_OFFSET, 32'h0200_0000);
    @(posedge clock);
    check("pullUpEn", 32'h0, 32'(pullUpEn));
    check("highVoltPullEn", 32'h0, 32'(highVoltPullEn));
    apb(1'b0, `PP_CFG_OFFSET, 32'h0);
    check("config", 32'h0200_0000, q);
    $display("test regs done");
  endtask

  task t_hard;
    busStart <= 1'b1;
    hardResetInN <= 1'b0;
    configValid <= 1'b0;
    @(posedge clock);
    busStart <= 1'b0;
    repeat (5) @(posedge clock);
    check("drain select", 32'hA, 32'(voltSelect));
    apb(1'b0, `PP_STAT_OFFSET, 32'h0);
    check("drain status", 32'h0000_030A, q);
    for (int n = 0; n < 20 && busPending !== 1'b0; n++)
      @(posedge clock);
    give_up(busPending === 1'b0);
    repeat (2) @(posedge clock);
    check("voltSelect", 32'hF, 32'(voltSelect));
    check("generalPullDisable", 32'h0, 32'(generalPullDisable));
    check("specialPullDisable", 32'h0, 32'(specialPullDisable));
    hardResetInN <= 1'b1;
    lowVoltFunc <= 4'hC;
    debugFunc <= 4'h0;
    configValid <= 1'b1;
    run_wait;
    check("voltSelect", 32'h3, 32'(voltSelect));
    check("specialPullEn", 32'h7, 32'(specialPullEn));
    $display("test hard done");
  endtask

  initial
  begin
    t_por;
    t_release;
    t_regs;
    t_hard;
    complete_run;
  end
endmodule
`default_nettype wire
